// *** hw/cpj_config_port.sv ***
// configuration port: boundary-scan tap, scheme pin roles and load arbitration
`timescale 1ns/10ps
`include "cpj_defines.svh"

// What this block does
// - scan configuration beats every other load mode
// - scan start aborts a passive serial load
// - no config clock out during scan load
// - user pins float during scan configuration
// - link needs just TDI, TDO, TMS, TCK
// - TDI captured on rising TCK edge
// - TDO launched on falling edge, else floats
// - tap samples TMS on rising TCK edge
// - chained devices share data and clock
// - spare chain enable out acts user pin
// - select drives flash enable, data1 reuse
// - user clock source optional, 40 MHz max
module cpj_config_port #(
  parameter bit HAS_USER_CLK = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tdi,
  input wire logic tms,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [`CPJ_SCHEME_W-1:0] config_scheme_select,
  input wire logic config_start_n,
  input wire logic chain_enable_in_n,
  input wire logic use_user_clock,
  input wire logic user_supplied_clock,
  input wire logic config_clock_in,
  output logic config_clock_out,
  output logic config_clock_oe,
  input wire logic data0_in,
  output logic data0_out,
  output logic data0_oe,
  input wire logic data1_in,
  output logic active_serial_data_out,
  output logic data1_oe,
  output logic serial_flash_select_n,
  output logic chain_enable_out_n,
  input wire logic chain_out_is_user_io,
  input wire logic user_io_value,
  output logic [`CPJ_USER_IO_W-1:0] user_io_oe,
  output logic [`CPJ_WORD_W-1:0] load_word,
  output logic load_valid,
  input wire logic load_ready,
  output logic [1:0] load_source,
  output logic scan_active
);
  // ---------------- link domain (tck) ----------------
  typedef struct packed {
    cpj_pkg::cpj_tap_t tap;
    logic [`CPJ_IR_W-1:0] ir_sh;
    logic [`CPJ_IR_W-1:0] ir;
    logic [`CPJ_WORD_W-1:0] dr_sh;
    logic [`CPJ_WORD_W-1:0] word;
    logic word_tgl;
    logic scan_lvl;
    logic ack_s1;
    logic ack_s2;
    logic busy;
  } cpj_tck_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } cpj_tckn_t;

  cpj_tck_t t_q, t_d;
  cpj_tckn_t n_q, n_d;
  logic trst_s1, trst_s2;
  logic ack_tgl_q;

  // reset reaches the link side through two flops of its own
  always_ff @(posedge tck) begin
    trst_s1 <= rst;
    trst_s2 <= trst_s1;
  end

  function automatic cpj_pkg::cpj_tap_t tap_next(input cpj_pkg::cpj_tap_t s, input logic m);
    case (s)
      cpj_pkg::CPJ_RESET: tap_next = m ? cpj_pkg::CPJ_RESET : cpj_pkg::CPJ_IDLE;
      cpj_pkg::CPJ_IDLE: tap_next = m ? cpj_pkg::CPJ_SEL_DR : cpj_pkg::CPJ_IDLE;
      cpj_pkg::CPJ_SEL_DR: tap_next = m ? cpj_pkg::CPJ_SEL_IR : cpj_pkg::CPJ_CAP_DR;
      cpj_pkg::CPJ_CAP_DR: tap_next = m ? cpj_pkg::CPJ_EX1_DR : cpj_pkg::CPJ_SH_DR;
      cpj_pkg::CPJ_SH_DR: tap_next = m ? cpj_pkg::CPJ_EX1_DR : cpj_pkg::CPJ_SH_DR;
      cpj_pkg::CPJ_EX1_DR: tap_next = m ? cpj_pkg::CPJ_UP_DR : cpj_pkg::CPJ_PA_DR;
      cpj_pkg::CPJ_PA_DR: tap_next = m ? cpj_pkg::CPJ_EX2_DR : cpj_pkg::CPJ_PA_DR;
      cpj_pkg::CPJ_EX2_DR: tap_next = m ? cpj_pkg::CPJ_UP_DR : cpj_pkg::CPJ_SH_DR;
      cpj_pkg::CPJ_UP_DR: tap_next = m ? cpj_pkg::CPJ_SEL_DR : cpj_pkg::CPJ_IDLE;
      cpj_pkg::CPJ_SEL_IR: tap_next = m ? cpj_pkg::CPJ_RESET : cpj_pkg::CPJ_CAP_IR;
      cpj_pkg::CPJ_CAP_IR: tap_next = m ? cpj_pkg::CPJ_EX1_IR : cpj_pkg::CPJ_SH_IR;
      cpj_pkg::CPJ_SH_IR: tap_next = m ? cpj_pkg::CPJ_EX1_IR : cpj_pkg::CPJ_SH_IR;
      cpj_pkg::CPJ_EX1_IR: tap_next = m ? cpj_pkg::CPJ_UP_IR : cpj_pkg::CPJ_PA_IR;
      cpj_pkg::CPJ_PA_IR: tap_next = m ? cpj_pkg::CPJ_EX2_IR : cpj_pkg::CPJ_PA_IR;
      cpj_pkg::CPJ_EX2_IR: tap_next = m ? cpj_pkg::CPJ_UP_IR : cpj_pkg::CPJ_SH_IR;
      default: tap_next = m ? cpj_pkg::CPJ_SEL_DR : cpj_pkg::CPJ_IDLE;
    endcase
  endfunction

  always_comb begin
    t_d = t_q;
    t_d.ack_s1 = ack_tgl_q;
    t_d.ack_s2 = t_q.ack_s1;
    t_d.tap = tap_next(t_q.tap, tms);
    case (t_q.tap)
      cpj_pkg::CPJ_CAP_IR: t_d.ir_sh = `CPJ_IR_W'(1);
      cpj_pkg::CPJ_SH_IR: t_d.ir_sh = {tdi, t_q.ir_sh[`CPJ_IR_W-1:1]};
      cpj_pkg::CPJ_UP_IR: t_d.ir = t_q.ir_sh;
      cpj_pkg::CPJ_CAP_DR: t_d.dr_sh = t_q.word;
      cpj_pkg::CPJ_SH_DR: t_d.dr_sh = {tdi, t_q.dr_sh[`CPJ_WORD_W-1:1]};
      cpj_pkg::CPJ_UP_DR: begin
        // a word is only handed over once the previous one was taken
        if (t_q.ir == `CPJ_IR_PROGRAM && !t_q.busy) begin
          t_d.word = t_q.dr_sh;
          t_d.word_tgl = ~t_q.word_tgl;
          t_d.busy = 1'b1;
        end
      end
      default: begin
      end
    endcase
    if (t_q.busy && t_q.ack_s2 == t_q.word_tgl) begin
      t_d.busy = 1'b0;
    end
    t_d.scan_lvl = (t_q.ir == `CPJ_IR_PROGRAM) && (t_q.tap != cpj_pkg::CPJ_RESET);
    if (t_q.tap == cpj_pkg::CPJ_RESET) begin
      t_d.ir = `CPJ_IR_RESET;
    end
    if (trst_s2) begin
      t_d = '0;
      t_d.tap = cpj_pkg::CPJ_RESET;
      t_d.ir = `CPJ_IR_RESET;
    end
  end

  always_ff @(posedge tck) begin
    t_q <= t_d;
  end

  always_comb begin
    n_d.tdo_oe = (t_q.tap == cpj_pkg::CPJ_SH_DR) || (t_q.tap == cpj_pkg::CPJ_SH_IR);
    n_d.tdo = (t_q.tap == cpj_pkg::CPJ_SH_IR) ? t_q.ir_sh[0] : t_q.dr_sh[0];
  end

  // launching on the falling edge gives the host half a period of setup
  always_ff @(negedge tck) begin
    n_q <= n_d;
  end

  assign tdo = n_q.tdo;
  assign tdo_oe = n_q.tdo_oe;

  // ---------------- system domain (clk) ----------------
  typedef struct packed {
    logic scan_s1;
    logic scan_s2;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_seen;
    logic ack_tgl;
    cpj_pkg::cpj_load_t load;
    logic [`CPJ_WORD_W-1:0] shift;
    logic [2:0] bitcnt;
    logic cs1, cs2, cd1, cd2, us1, us2, ps1, ps2, d01, d02, d11, d12;
    logic cclk_prev;
    logic [3:0] div;
    logic cclk;
    logic [`CPJ_BUF_DEPTH-1:0][`CPJ_WORD_W-1:0] buf_mem;
    logic [`CPJ_BUF_DEPTH-1:0] buf_full;
    logic wr_idx, rd_idx, pend;
    logic [`CPJ_SCHEME_W-1:0] scheme_s1, scheme;
    logic cclk_oe, d0_oe, d1_oe, d1, sel_n, ceo_n;
    logic [`CPJ_USER_IO_W-1:0] uio_oe;
  } cpj_sys_t;

  cpj_sys_t s_q, s_d;
  logic push, pop, in_ready, scan_on, cclk_rise, cclk_src;

  assign ack_tgl_q = s_q.ack_tgl;

  always_comb begin
    s_d = s_q;
    s_d.scan_s1 = t_q.scan_lvl;
    s_d.scan_s2 = s_q.scan_s1;
    s_d.tgl_s1 = t_q.word_tgl;
    s_d.tgl_s2 = s_q.tgl_s1;
    s_d.cs1 = config_start_n; s_d.cs2 = s_q.cs1;
    s_d.cd1 = config_clock_in; s_d.cd2 = s_q.cd1;
    s_d.us1 = user_supplied_clock; s_d.us2 = s_q.us1;
    s_d.ps1 = chain_enable_in_n; s_d.ps2 = s_q.ps1;
    s_d.d01 = data0_in; s_d.d02 = s_q.d01;
    s_d.d11 = data1_in; s_d.d12 = s_q.d11;
    s_d.scheme_s1 = config_scheme_select;
    s_d.scheme = s_q.scheme_s1;
    scan_on = s_q.scan_s2;
    in_ready = !s_q.buf_full[s_q.wr_idx];
    push = 1'b0;
    // the user clock is a legal source only on variants that have one
    cclk_src = (HAS_USER_CLK && use_user_clock) ? s_q.us2 : s_q.cclk;
    cclk_rise = (s_q.scheme == `CPJ_SCHEME_AS || s_q.scheme == `CPJ_SCHEME_AP) ?
                (cclk_src && !s_q.cclk_prev) : (s_q.cd2 && !s_q.cclk_prev);
    s_d.cclk_prev = (s_q.scheme == `CPJ_SCHEME_AS || s_q.scheme == `CPJ_SCHEME_AP) ?
                    cclk_src : s_q.cd2;
    s_d.div = (s_q.div == 4'(`CPJ_USRCLK_DIV - 1)) ? 4'h0 : s_q.div + 4'h1;
    if (s_q.div == 4'h0) begin
      s_d.cclk = ~s_q.cclk;
    end
    // scan configuration preempts any serial load in flight
    if (scan_on && !s_q.ps2) begin
      s_d.load = cpj_pkg::CPJ_SCAN;
      s_d.bitcnt = 3'h0;
      s_d.pend = 1'b0;
    end else if (s_q.load == cpj_pkg::CPJ_SCAN) begin
      s_d.load = cpj_pkg::CPJ_OFF;
    end else if (!s_q.cs2) begin
      s_d.load = cpj_pkg::CPJ_OFF;
      s_d.bitcnt = 3'h0;
      s_d.pend = 1'b0;
    end else if (!s_q.ps2) begin
      s_d.load = cpj_pkg::CPJ_SERIAL;
    end
    if (s_q.load == cpj_pkg::CPJ_SCAN && s_q.tgl_s2 != s_q.tgl_seen && in_ready) begin
      push = 1'b1;
      s_d.shift = t_q.word; // stable: tck side holds it until acked
      s_d.tgl_seen = s_q.tgl_s2;
      s_d.ack_tgl = s_q.tgl_s2;
    end else if (s_q.load == cpj_pkg::CPJ_SERIAL && s_q.pend) begin
      // a finished word waits for room; bits arriving meanwhile are dropped
      push = in_ready;
      s_d.pend = !in_ready;
    end else if (s_q.load == cpj_pkg::CPJ_SERIAL && cclk_rise) begin
      // parallel schemes bring in data1 alongside data0, serial ones one bit
      if (s_q.scheme == `CPJ_SCHEME_FPP || s_q.scheme == `CPJ_SCHEME_AP) begin
        s_d.shift = {s_q.d12, s_q.d02, s_q.shift[`CPJ_WORD_W-1:2]};
        s_d.bitcnt = s_q.bitcnt + 3'h2;
        push = (s_q.bitcnt == 3'h6) && in_ready;
        s_d.pend = (s_q.bitcnt == 3'h6) && !in_ready;
      end else begin
        s_d.shift = {s_q.d02, s_q.shift[`CPJ_WORD_W-1:1]};
        s_d.bitcnt = s_q.bitcnt + 3'h1;
        push = (s_q.bitcnt == 3'h7) && in_ready;
        s_d.pend = (s_q.bitcnt == 3'h7) && !in_ready;
      end
    end
    pop = s_q.buf_full[s_q.rd_idx] && load_ready;
    if (push) begin
      s_d.buf_mem[s_q.wr_idx] = (s_q.load == cpj_pkg::CPJ_SCAN) ? t_q.word : s_d.shift;
      s_d.buf_full[s_q.wr_idx] = 1'b1;
      s_d.wr_idx = ~s_q.wr_idx;
    end
    if (pop) begin
      s_d.buf_full[s_q.rd_idx] = 1'b0;
      s_d.rd_idx = ~s_q.rd_idx;
    end
    // pin roles per scheme
    s_d.cclk_oe = (s_q.scheme == `CPJ_SCHEME_AS || s_q.scheme == `CPJ_SCHEME_AP) &&
                  !scan_on;
    s_d.d0_oe = (s_q.scheme == `CPJ_SCHEME_AP) && !scan_on && !s_q.cs2;
    s_d.d1_oe = (s_q.scheme == `CPJ_SCHEME_AS) && !scan_on;
    s_d.d1 = s_q.shift[0];
    // one select pin serves the serial memory and the parallel flash
    s_d.sel_n = !((s_q.scheme == `CPJ_SCHEME_AS || s_q.scheme == `CPJ_SCHEME_AP) &&
                  s_q.load == cpj_pkg::CPJ_SERIAL);
    s_d.ceo_n = chain_out_is_user_io ? user_io_value : (s_q.load == cpj_pkg::CPJ_OFF);
    s_d.uio_oe = scan_on ? '0 : '1;
    if (rst) begin
      s_d = '0;
      s_d.sel_n = 1'b1;
      s_d.ceo_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign config_clock_out = s_q.cclk;
  assign config_clock_oe = s_q.cclk_oe;
  assign data0_out = 1'b0;
  assign data0_oe = s_q.d0_oe;
  assign active_serial_data_out = s_q.d1;
  assign data1_oe = s_q.d1_oe;
  assign serial_flash_select_n = s_q.sel_n;
  assign chain_enable_out_n = s_q.ceo_n;
  assign user_io_oe = s_q.uio_oe;
  assign load_word = s_q.buf_mem[s_q.rd_idx];
  assign load_valid = s_q.buf_full[s_q.rd_idx];
  assign load_source = s_q.load;
  assign scan_active = s_q.scan_s2;

  a_scan_floats_io: assert property (@(posedge clk) disable iff (rst)
    s_q.scan_s2 |=> (user_io_oe == '0)) else $error("user io driven during scan");
  a_scan_no_cclk: assert property (@(posedge clk) disable iff (rst)
    s_q.scan_s2 |=> !config_clock_oe) else $error("config clock driven in scan");
  sequence s_scan_start;
    s_q.scan_s2 && !s_q.ps2;
  endsequence
  a_scan_preempts: assert property (@(posedge clk) disable iff (rst)
    s_scan_start |=> (load_source == 2'h2)) else $error("scan did not preempt");
  a_tdo_float_idle: assert property (@(negedge tck) disable iff (trst_s2)
    (t_q.tap == cpj_pkg::CPJ_IDLE) |=> !tdo_oe) else $error("tdo driven idle");
  a_tap_reset_tms: assert property (@(posedge tck) disable iff (trst_s2)
    tms [*5] |=> (t_q.tap == cpj_pkg::CPJ_RESET)) else $error("tap not reset");
  a_ir_capture: assert property (@(posedge tck) disable iff (trst_s2)
    (t_q.tap == cpj_pkg::CPJ_SH_IR) |=> (t_q.ir_sh[`CPJ_IR_W-1] == $past(tdi)))
    else $error("tdi not captured");
  a_buf_no_overrun: assert property (@(posedge clk) disable iff (rst)
    (s_q.buf_full == 2'h3 && !load_ready) |=> (s_q.buf_full == 2'h3))
    else $error("buffer lost word");
  a_flash_select: assert property (@(posedge clk) disable iff (rst)
    (s_q.scheme == `CPJ_SCHEME_AP && s_q.load == cpj_pkg::CPJ_SERIAL)
    |=> !serial_flash_select_n) else $error("flash enable not driven");
endmodule

// *** hw/cpj_defines.svh ***
// constants for the configuration port with boundary-scan priority
`ifndef CPJ_DEFINES_SVH
`define CPJ_DEFINES_SVH
`define CPJ_SCHEME_W 2
`define CPJ_SCHEME_PS 2'h0
`define CPJ_SCHEME_AS 2'h1
`define CPJ_SCHEME_FPP 2'h2
`define CPJ_SCHEME_AP 2'h3
`define CPJ_IR_W 4
`define CPJ_IR_RESET 4'h1
`define CPJ_IR_PROGRAM 4'h2
`define CPJ_IR_BYPASS 4'hf
`define CPJ_WORD_W 8
`define CPJ_USER_IO_W 8
`define CPJ_CLK_MHZ 200
`define CPJ_USRCLK_MAX_MHZ 40
`define CPJ_USRCLK_DIV ((`CPJ_CLK_MHZ + `CPJ_USRCLK_MAX_MHZ - 1) / `CPJ_USRCLK_MAX_MHZ)
`define CPJ_CCLK_DIV 4
`define CPJ_BUF_DEPTH 2
`endif

// *** hw/cpj_pkg.sv ***
// types for the configuration port with boundary-scan priority
package cpj_pkg;
  typedef enum logic [3:0] {
    CPJ_RESET = 4'h0, CPJ_IDLE = 4'h1, CPJ_SEL_DR = 4'h2, CPJ_CAP_DR = 4'h3,
    CPJ_SH_DR = 4'h4, CPJ_EX1_DR = 4'h5, CPJ_PA_DR = 4'h6, CPJ_EX2_DR = 4'h7,
    CPJ_UP_DR = 4'h8, CPJ_SEL_IR = 4'h9, CPJ_CAP_IR = 4'ha, CPJ_SH_IR = 4'hb,
    CPJ_EX1_IR = 4'hc, CPJ_PA_IR = 4'hd, CPJ_EX2_IR = 4'he, CPJ_UP_IR = 4'hf
  } cpj_tap_t;
  typedef enum logic [1:0] {
    CPJ_OFF = 2'h0, CPJ_SERIAL = 2'h1, CPJ_SCAN = 2'h2
  } cpj_load_t;
endpackage

// *** test/cpj_jtag_host.sv ***
// download-cable host model driving the test access port
`timescale 1ns/10ps
module cpj_jtag_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_oe
);
  int oe_hits = 0;

  // link clock stands low (pull-down) between frames, tms and tdi float high (pull-ups)
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  always @(posedge tck) begin
    if (tdo_oe === 1'b1) begin
      oe_hits <= oe_hits + 1;
    end
  end

  // one 12 ns link cycle on tck, tms and tdi; tms and tdi settle half a period early
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #6 tck = 1'b1;
    #6 tck = 1'b0;
  endtask

  // program instruction, then one data word, lsb first, back to idle
  task automatic load(input logic [3:0] ir, input logic [7:0] dr);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    for (int i = 0; i < 4; i++) step(1'(i == 3), ir[i]);
    step(1'b1, 1'b1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    for (int i = 0; i < 8; i++) step(1'(i == 7), dr[i]);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    tms = 1'b1;
  endtask
endmodule

// *** test/cpj_config_port_test.sv ***
// self-checking bench for the configuration port
`timescale 1ns/10ps
`include "cpj_defines.svh"
module cpj_config_port_test;
  typedef struct packed {
    logic [1:0] scheme;
    logic start_n;
    logic uval;
    logic [2:0] oe;
  } cpj_row_t;
  logic clk, rst, tck, tdi, tms, tdo_oe, config_start_n, config_clock_in, data0_in;
  logic load_ready, user_io_value, config_clock_oe, data0_oe, data1_oe;
  logic chain_enable_out_n, load_valid, scan_active;
  logic [1:0] config_scheme_select, load_source;
  logic [`CPJ_WORD_W-1:0] user_io_oe, load_word;
  int miscompares = 0;
  int n_compared = 0;
  // oe holds {config clock, data1, data0} enables
  cpj_row_t rows [5] = '{
    '{`CPJ_SCHEME_PS, 1'b1, 1'b0, 3'h0},
    '{`CPJ_SCHEME_AS, 1'b1, 1'b1, 3'h6},
    '{`CPJ_SCHEME_FPP, 1'b1, 1'b0, 3'h0},
    '{`CPJ_SCHEME_AP, 1'b1, 1'b1, 3'h4},
    '{`CPJ_SCHEME_AP, 1'b0, 1'b0, 3'h5}};

  cpj_config_port u_dut (.clk(clk), .rst(rst), .tck(tck), .tdi(tdi), .tms(tms), .tdo(),
    .tdo_oe(tdo_oe), .config_scheme_select(config_scheme_select),
    .config_start_n(config_start_n), .chain_enable_in_n(1'b0),
    .use_user_clock(1'b0), .user_supplied_clock(1'b0), .config_clock_in(config_clock_in),
    .config_clock_out(), .config_clock_oe(config_clock_oe), .data0_in(data0_in),
    .data0_out(), .data0_oe(data0_oe), .data1_in(1'b0), .active_serial_data_out(),
    .data1_oe(data1_oe), .serial_flash_select_n(), .chain_enable_out_n(chain_enable_out_n),
    .chain_out_is_user_io(1'b1), .user_io_value(user_io_value), .user_io_oe(user_io_oe),
    .load_word(load_word), .load_valid(load_valid), .load_ready(load_ready),
    .load_source(load_source), .scan_active(scan_active));
  cpj_jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo_oe(tdo_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // tap is walked to its reset state by five tms-high cycles while rst is held
  task automatic do_reset(input logic [1:0] s);
    rst = 1'b1;
    config_scheme_select = s;
    repeat (5) u_host.step(1'b1, 1'b1);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    // the link side only leaves reset once tck has carried the release through
    repeat (3) u_host.step(1'b1, 1'b1);
    @(negedge clk);
  endtask

  // slow enough for the two-flop synchroniser on the external config clock
  task automatic ser_bits(input logic [7:0] b, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      data0_in = b[i];
      repeat (4) @(negedge clk);
      config_clock_in = 1'b1;
      repeat (4) @(negedge clk);
      config_clock_in = 1'b0;
    end
  endtask

  // words from another source are drained on the way, the wanted one is checked
  task automatic take(input logic [7:0] exp, input logic [1:0] src);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      load_ready = (load_valid === 1'b1);
    end while (!(load_valid === 1'b1 && load_source === src) && n < 400);
    if (n >= 400) begin
      miscompares++;
      finish_test();
    end
    check("load_word", exp, load_word);
    if (src == 2'h2) begin
      check("scan_active", 8'h1, 8'(scan_active));
      check("user_io_oe_scan", 8'h0, user_io_oe);
      check("config_clock_oe_scan", 8'h0, 8'(config_clock_oe));
    end
    @(negedge clk);
    load_ready = 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    config_scheme_select = `CPJ_SCHEME_PS;
    config_start_n = 1'b1;
    config_clock_in = 1'b0;
    data0_in = 1'b0;
    load_ready = 1'b0;
    user_io_value = 1'b0;
    foreach (rows[i]) begin
      user_io_value = rows[i].uval;
      config_start_n = rows[i].start_n;
      do_reset(rows[i].scheme);
      repeat (8) @(negedge clk);
      check("pin_oe", 8'(rows[i].oe), 8'({config_clock_oe, data1_oe, data0_oe}));
      check("chain_out_n", 8'(rows[i].uval), 8'(chain_enable_out_n));
      check("tdo_oe_idle", 8'h0, 8'(tdo_oe));
      check("user_io_oe", 8'hff, user_io_oe);
    end
    config_start_n = 1'b1;
    do_reset(`CPJ_SCHEME_AS);
    u_host.load(`CPJ_IR_PROGRAM, 8'h3c);
    take(8'h3c, 2'h2);
    check("tdo_oe_shift", 8'h1, 8'(u_host.oe_hits > 0));
    do_reset(`CPJ_SCHEME_PS);
    check("valid_after_reset", 8'h0, 8'(load_valid));
    // receiver stalls: two words buffered, the third waits in the shifter
    ser_bits(8'h11, 8);
    ser_bits(8'h22, 8);
    ser_bits(8'h33, 8);
    repeat (8) @(negedge clk);
    check("stalled_word", 8'h11, load_word);
    take(8'h11, 2'h1);
    take(8'h22, 2'h1);
    take(8'h33, 2'h1);
    check("drained", 8'h0, 8'(load_valid));
    ser_bits(8'h0f, 4);
    u_host.load(`CPJ_IR_PROGRAM, 8'ha5);
    take(8'ha5, 2'h2);
    // tap reset ends the scan load; the aborted four bits must not count
    repeat (5) u_host.step(1'b1, 1'b1);
    repeat (8) @(negedge clk);
    ser_bits(8'h0f, 4);
    repeat (8) @(negedge clk);
    check("aborted_serial", 8'h0, 8'(load_valid));
    finish_test();
  end
endmodule
